// ---- rtl/can_pkg.sv ----
// Constants for the mailbox status and timestamp timer register block.
package can_pkg;

  // ==========================================================================
  // Register map, word index on the bus
  localparam logic [7:0] MASTER_CONTROL      = 8'h00;
  localparam logic [7:0] ERROR_COUNTERS      = 8'h01;
  localparam logic [7:0] TRANSMIT_PENDING    = 8'h02;
  localparam logic [7:0] TRANSMIT_CANCEL     = 8'h04;
  localparam logic [7:0] TRANSMIT_DONE       = 8'h06;
  localparam logic [7:0] ABORT_DONE          = 8'h08;
  localparam logic [7:0] DATA_RECEIVED       = 8'h0a;
  localparam logic [7:0] REMOTE_RECEIVED     = 8'h0c;
  localparam logic [7:0] MAILBOX_IRQ_MASK    = 8'h0e;
  localparam logic [7:0] OVERWRITE_STATUS    = 8'h10;
  localparam logic [7:0] TIMER_COUNT         = 8'h12;
  localparam logic [7:0] TIMER_CONTROL       = 8'h13;
  localparam logic [7:0] TIMER_STATUS        = 8'h14;
  localparam logic [7:0] TIMER_RELOAD_OFFSET = 8'h15;
  localparam logic [7:0] SYNC_CAPTURE        = 8'h16;
  localparam logic [7:0] TIMESTAMP_CAPTURE   = 8'h17;
  localparam logic [7:0] TIMER_COMPARE_ZERO  = 8'h18;
  localparam logic [7:0] TIMER_COMPARE_ONE   = 8'h19;
  localparam logic [7:0] INTERRUPT_FLAGS     = 8'h1a;
  localparam logic [7:0] INTERRUPT_MASK      = 8'h1b;
  localparam logic [7:0] MAILBOX_BASE        = 8'h40;

  // ==========================================================================
  // Field positions
  localparam int MC_TEST_MODE     = 15;
  localparam int MC_COUNTER_WRITE = 14;
  localparam int MC_FORCE_PASSIVE = 13;
  localparam int TC_RUN           = 15;
  localparam int TC_CAPTURE_ZERO  = 14;
  localparam int TC_CAPTURE_POINT = 13;
  localparam int TC_COMPARE_CLEAR = 11;
  localparam int IF_COMPARE_ONE   = 15;
  localparam int IF_COMPARE_ZERO  = 14;
  localparam int IF_OVERFLOW      = 13;
  localparam int TS_COMPARE_ONE   = 2;
  localparam int TS_COMPARE_ZERO  = 1;
  localparam int TS_OVERFLOW      = 0;
  localparam int FIELD_CONTROL    = 0;
  localparam int FIELD_DATA       = 1;
  localparam int FIELD_STAMP      = 2;
  localparam int FIELD_MASK       = 3;
  localparam int CONFIG_LSB       = 0;
  localparam int IDENT_LSB        = 5;

  // ==========================================================================
  // Reset values and limits
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  localparam logic [15:0] IMASK_RESET     = 16'hffff;
  localparam logic [31:0] MBOX_MASK_RESET = 32'hffff_ffff;
  localparam logic [31:0] RX_ONLY_BOXES   = 32'h8000_0001;
  localparam logic [7:0]  PASSIVE_LIMIT   = 8'h80;
  localparam logic [7:0]  TX_ERROR_STEP   = 8'h08;
  localparam logic [15:0] FLAG_BITS       = 16'he000;

endpackage

// ---- rtl/timer_if.sv ----
// Link between the register block and its timestamp timer.
`timescale 1ns/1ps
interface timer_if;
  logic        wr;
  logic [7:0]  sel;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] stamp;
  logic        frame_start;
  logic        frame_end;
  logic        id_match;
  logic        request;

  modport main  (output wr, sel, wdata, frame_start, frame_end, id_match,
                 input rdata, stamp, request);
  modport timer (input wr, sel, wdata, frame_start, frame_end, id_match,
                 output rdata, stamp, request);
endinterface

// ---- rtl/stamp_timer.sv ----
// Free-running timestamp timer with reload, two captures and two compares.
`timescale 1ns/1ps
module stamp_timer (
  input wire logic mclk,
  input wire logic rst,
  timer_if.timer   tmr
);
  import can_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] control;
    logic [15:0] reload;
    logic [15:0] capture0;
    logic [15:0] capture1;
    logic [15:0] compare0;
    logic [15:0] compare1;
    logic [15:0] flags;
    logic [15:0] mask;
  } timer_state_t;

  timer_state_t cur;
  timer_state_t next_cur;
  logic         match0;
  logic         match1;
  logic         overflow;
  logic         cap_event;

  // ==========================================================================
  // Events
  assign match0    = (cur.compare0 != WORD_RESET) && (cur.count == cur.compare0);
  assign match1    = (cur.compare1 != WORD_RESET) && (cur.count == cur.compare1);
  assign overflow  = cur.control[TC_RUN] && (cur.count == 16'hffff);
  assign cap_event = cur.control[TC_CAPTURE_POINT] ? tmr.frame_end : tmr.frame_start;

  always_comb begin
    logic [15:0] set_flags;
    logic [15:0] clr_flags;
    set_flags = WORD_RESET;
    clr_flags = WORD_RESET;
    next_cur  = cur;
    // Counter: a software write wins, then a load of the reload offset, then the increment.
    if (tmr.wr && tmr.sel == TIMER_COUNT) begin
      next_cur.count = tmr.wdata;
    end else if (overflow || (match0 && cur.control[TC_COMPARE_CLEAR]) || tmr.id_match) begin
      next_cur.count = cur.reload;
    end else if (cur.control[TC_RUN]) begin
      next_cur.count = cur.count + 16'h0001;
    end
    if (cap_event && cur.control[TC_CAPTURE_ZERO]) begin
      next_cur.capture0 = cur.count;
    end
    if (cap_event) begin
      next_cur.capture1 = cur.count;
    end
    set_flags[IF_COMPARE_ONE]  = match1;
    set_flags[IF_COMPARE_ZERO] = match0;
    set_flags[IF_OVERFLOW]     = overflow;
    if (tmr.wr) begin
      case (tmr.sel)
        TIMER_CONTROL:       next_cur.control  = tmr.wdata;
        TIMER_RELOAD_OFFSET: next_cur.reload   = tmr.wdata;
        SYNC_CAPTURE:        next_cur.capture0 = tmr.wdata;
        TIMESTAMP_CAPTURE:   next_cur.capture1 = tmr.wdata;
        TIMER_COMPARE_ZERO:  next_cur.compare0 = tmr.wdata;
        TIMER_COMPARE_ONE:   next_cur.compare1 = tmr.wdata;
        INTERRUPT_FLAGS:     clr_flags         = tmr.wdata & FLAG_BITS;
        INTERRUPT_MASK:      next_cur.mask     = tmr.wdata;
        default:             next_cur.count    = next_cur.count;
      endcase
    end
    // A match in the clearing cycle still lands.
    next_cur.flags = ((cur.flags & ~clr_flags) | set_flags) & FLAG_BITS;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur          <= '0;
      cur.mask     <= IMASK_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Readback; status mirrors the flags so a flag clear also clears status.
  always_comb begin
    case (tmr.sel)
      TIMER_COUNT:         tmr.rdata = cur.count;
      TIMER_CONTROL:       tmr.rdata = cur.control;
      TIMER_STATUS:        tmr.rdata = {13'h0000, cur.flags[IF_COMPARE_ONE],
                                        cur.flags[IF_COMPARE_ZERO], cur.flags[IF_OVERFLOW]};
      TIMER_RELOAD_OFFSET: tmr.rdata = cur.reload;
      SYNC_CAPTURE:        tmr.rdata = cur.capture0;
      TIMESTAMP_CAPTURE:   tmr.rdata = cur.capture1;
      TIMER_COMPARE_ZERO:  tmr.rdata = cur.compare0;
      TIMER_COMPARE_ONE:   tmr.rdata = cur.compare1;
      INTERRUPT_FLAGS:     tmr.rdata = cur.flags;
      INTERRUPT_MASK:      tmr.rdata = cur.mask;
      default:             tmr.rdata = WORD_RESET;
    endcase
  end

  assign tmr.stamp   = cur.count;
  assign tmr.request = |(cur.flags & ~cur.mask);

endmodule // stamp_timer

// ---- rtl/can_regs.sv ----
// Mailbox status, error counter and mailbox store with its timestamp timer.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module can_regs #(
  parameter int MAILBOXES = 32
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [31:0] tx_complete,
  input  wire logic [31:0] tx_aborted,
  input  wire logic [31:0] rx_data_frame,
  input  wire logic [31:0] rx_remote_frame,
  input  wire logic        rx_store,
  input  wire logic [4:0]  rx_mailbox,
  input  wire logic [10:0] rx_identifier,
  input  wire logic        tx_error,
  input  wire logic        tx_success,
  input  wire logic        rx_error,
  input  wire logic        rx_success,
  input  wire logic        frame_start,
  input  wire logic        frame_end,
  input  wire logic        id_compare_match,
  output logic      [31:0] transmit_pending,
  output logic      [31:0] transmit_cancel,
  output logic      [31:0] acceptance_mask_on,
  output logic             error_passive,
  output logic             test_mode,
  output logic             mailbox_request,
  output logic             timer_request
);
  import can_pkg::*;

  localparam int MB_WORDS = MAILBOXES * 4;

  if (MAILBOXES != 32) begin : g_check
    $error("can_regs serves exactly 32 mailboxes");
  end

  typedef struct packed {
    logic [15:0] master_control;
    logic [7:0]  transmit_error_counter;
    logic [7:0]  receive_error_counter;
    logic [31:0] pending;
    logic [31:0] cancel;
    logic [31:0] tx_done;
    logic [31:0] abort_done;
    logic [31:0] rx_data;
    logic [31:0] rx_remote;
    logic [31:0] irq_mask;
    logic [31:0] overwrite;
    logic        ack;
    logic [31:0] readdata;
  } reg_state_t;

  reg_state_t  cur;
  reg_state_t  next_cur;
  logic [15:0] mailbox_ram [MB_WORDS];
  logic        do_write;
  logic        in_mailbox;
  logic [6:0]  mb_index;
  logic [1:0]  mb_field;
  logic        word_access;
  logic        test_on;
  logic [15:0] wword;
  logic [6:0]  rx_ctrl_index;
  logic [2:0]  rx_config;
  logic        rx_masked;

  timer_if tmr ();

  stamp_timer u_timer (
    .mclk (mclk),
    .rst  (rst),
    .tmr  (tmr.timer)
  );

  // ==========================================================================
  // Bus slave: one wait cycle, then the answer; a write lands on the edge after the ack edge.
  assign avs_waitrequest = (avs_read || avs_write) && !cur.ack;
  assign do_write        = avs_write && cur.ack;
  assign avs_readdata    = cur.readdata;
  assign in_mailbox      = avs_address >= MAILBOX_BASE
                           && avs_address < MAILBOX_BASE + 8'(MB_WORDS);
  assign mb_index        = 7'(avs_address - MAILBOX_BASE);
  assign mb_field        = mb_index[1:0];
  assign word_access     = avs_byteenable[1:0] == 2'b11;
  assign wword           = avs_writedata[15:0];
  assign test_on         = cur.master_control[MC_TEST_MODE];

  assign tmr.wr          = do_write && word_access && !in_mailbox;
  assign tmr.sel         = avs_address;
  assign tmr.wdata       = wword;
  assign tmr.frame_start = frame_start;
  assign tmr.frame_end   = frame_end;
  assign tmr.id_match    = id_compare_match;

  // Merge the written halves of a 32-bit pair register.
  function automatic logic [31:0] put_half(input logic [31:0] old, input logic hi,
                                           input logic [15:0] val);
    logic [31:0] res;
    res = old;
    if (hi) begin
      res[31:16] = val;
    end else begin
      res[15:0] = val;
    end
    return res;
  endfunction

  function automatic logic [15:0] get_half(input logic [31:0] v, input logic hi);
    return hi ? v[31:16] : v[15:0];
  endfunction

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hff : s[7:0];
  endfunction

  function automatic logic [7:0] sat_dec(input logic [7:0] a);
    return (a == 8'h00) ? 8'h00 : a - 8'h01;
  endfunction

  // ==========================================================================
  // Register state
  always_comb begin
    logic        hi;
    logic [7:0]  base;
    logic [31:0] w1c;
    logic [15:0] rd;
    hi       = avs_address[0];
    // Control and counter words stand alone; the mailbox sets above them are word pairs, the timer words stand alone.
    base     = (avs_address < TRANSMIT_PENDING) ? avs_address : {avs_address[7:1], 1'b0};
    w1c      = '0;
    rd       = WORD_RESET;
    next_cur = cur;
    next_cur.ack = (avs_read || avs_write) && !cur.ack;

    // Error counters follow the protocol events; test writes override.
    if (tx_error) begin
      next_cur.transmit_error_counter = sat_add(cur.transmit_error_counter, TX_ERROR_STEP);
    end else if (tx_success) begin
      next_cur.transmit_error_counter = sat_dec(cur.transmit_error_counter);
    end
    if (rx_error) begin
      next_cur.receive_error_counter = sat_add(cur.receive_error_counter, 8'h01);
    end else if (rx_success) begin
      next_cur.receive_error_counter = sat_dec(cur.receive_error_counter);
    end

    // Hardware clears of pending and cancel when a transfer ends.
    next_cur.pending = cur.pending & ~tx_complete & ~tx_aborted;
    next_cur.cancel  = cur.cancel & ~tx_complete & ~tx_aborted;

    if (do_write && word_access && !in_mailbox) begin
      case (base)
        MASTER_CONTROL: begin
          if (hi) begin
            next_cur.master_control = cur.master_control;
          end else begin
            next_cur.master_control = wword;
          end
        end
        ERROR_COUNTERS: begin
          if (test_on && cur.master_control[MC_COUNTER_WRITE]) begin
            next_cur.transmit_error_counter = wword[15:8];
            next_cur.receive_error_counter = wword[15:8];
          end
        end
        TRANSMIT_PENDING: begin
          next_cur.pending = next_cur.pending
                             | (put_half('0, hi, wword) & ~RX_ONLY_BOXES);
        end
        TRANSMIT_CANCEL: begin
          next_cur.cancel = next_cur.cancel | (put_half('0, hi, wword) & cur.pending);
        end
        TRANSMIT_DONE, ABORT_DONE, DATA_RECEIVED, REMOTE_RECEIVED, OVERWRITE_STATUS: begin
          w1c = put_half('0, hi, wword);
        end
        MAILBOX_IRQ_MASK: begin
          next_cur.irq_mask = put_half(cur.irq_mask, hi, wword);
        end
        default: begin
          w1c = '0;
        end
      endcase
    end

    // Flags set by hardware win over a clear in the same cycle.
    next_cur.tx_done    = (cur.tx_done & ~((base == TRANSMIT_DONE) ? w1c : '0))
                          | tx_complete;
    next_cur.abort_done = (cur.abort_done & ~((base == ABORT_DONE) ? w1c : '0))
                          | tx_aborted;
    next_cur.rx_data    = (cur.rx_data & ~((base == DATA_RECEIVED) ? w1c : '0))
                          | rx_data_frame;
    next_cur.rx_remote  = (cur.rx_remote & ~((base == REMOTE_RECEIVED) ? w1c : '0))
                          | rx_remote_frame;
    next_cur.overwrite  = (cur.overwrite & ~((base == OVERWRITE_STATUS) ? w1c : '0))
                          | (rx_data_frame & cur.rx_data);

    // Read data is sampled in the wait cycle and stands on the ack edge.
    if (in_mailbox) begin
      rd = mailbox_ram[mb_index];
    end else begin
      case (base)
        MASTER_CONTROL:   rd = hi ? WORD_RESET : cur.master_control;
        ERROR_COUNTERS:   rd = {cur.transmit_error_counter, cur.receive_error_counter};
        TRANSMIT_PENDING: rd = get_half(cur.pending, hi);
        TRANSMIT_CANCEL:  rd = get_half(cur.cancel, hi);
        TRANSMIT_DONE:    rd = get_half(cur.tx_done, hi);
        ABORT_DONE:       rd = get_half(cur.abort_done, hi);
        DATA_RECEIVED:    rd = get_half(cur.rx_data, hi);
        REMOTE_RECEIVED:  rd = get_half(cur.rx_remote, hi);
        MAILBOX_IRQ_MASK: rd = get_half(cur.irq_mask, hi);
        OVERWRITE_STATUS: rd = get_half(cur.overwrite, hi);
        default:          rd = tmr.rdata;
      endcase
    end
    next_cur.readdata = next_cur.ack ? {16'h0000, rd} : cur.readdata;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur          <= '0;
      cur.irq_mask <= MBOX_MASK_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Mailbox store: four words per mailbox, contents survive reset.
  assign rx_ctrl_index = {rx_mailbox, 2'(FIELD_CONTROL)};
  assign rx_config     = mailbox_ram[rx_ctrl_index][CONFIG_LSB +: 3];
  assign rx_masked     = acceptance_mask_on[rx_mailbox];

  always_ff @(posedge mclk) begin
    if (do_write && in_mailbox) begin
      if (mb_field == 2'(FIELD_DATA)) begin
        if (avs_byteenable[0]) begin
          mailbox_ram[mb_index][7:0] <= wword[7:0];
        end
        if (avs_byteenable[1]) begin
          mailbox_ram[mb_index][15:8] <= wword[15:8];
        end
      end else if (word_access) begin
        mailbox_ram[mb_index] <= wword;
      end
    end
    // The receiver's update is placed last so it wins over a software write.
    if (rx_store) begin
      mailbox_ram[{rx_mailbox, 2'(FIELD_STAMP)}] <= tmr.stamp;
      if (rx_masked) begin
        mailbox_ram[rx_ctrl_index] <= {rx_identifier,
                                       mailbox_ram[rx_ctrl_index][IDENT_LSB-1:0]};
      end
    end
  end

  // A mask is in force only for the four filtering configurations.
  for (genvar i = 0; i < MAILBOXES; i++) begin : g_mask
    logic [2:0] cfg;
    assign cfg = mailbox_ram[i * 4 + FIELD_CONTROL][CONFIG_LSB +: 3];
    assign acceptance_mask_on[i] = cfg == 3'b001 || cfg == 3'b010
                                   || cfg == 3'b100 || cfg == 3'b101;
  end

  // ==========================================================================
  // Outputs towards the protocol engine
  assign transmit_pending = cur.pending;
  assign transmit_cancel  = cur.cancel;
  assign test_mode        = test_on;
  assign error_passive    = (test_on && cur.master_control[MC_FORCE_PASSIVE])
                            || cur.transmit_error_counter >= PASSIVE_LIMIT || cur.receive_error_counter >= PASSIVE_LIMIT;
  assign mailbox_request  = |((cur.rx_data | cur.rx_remote | cur.tx_done | cur.abort_done)
                              & ~cur.irq_mask);
  assign timer_request    = tmr.request;

endmodule // can_regs

// ---- dv/can_regs_asserts.sv ----
// Concurrent checks on the register block ports.
`timescale 1ns/1ps
module can_regs_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] tx_complete,
  input wire logic        tx_error,
  input wire logic        rx_error,
  input wire logic [31:0] transmit_pending,
  input wire logic [31:0] transmit_cancel,
  input wire logic        error_passive,
  input wire logic        test_mode
);
  import can_pkg::*;
  // ==========================================================================
  // Bus and status relations
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("waitrequest held too long");
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest without request");
  property p_upper; avs_readdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_mode;
    $changed(test_mode) |-> $past(avs_write && !avs_waitrequest && avs_address == MASTER_CONTROL);
  endproperty
  a_mode: assert property (p_mode) else $error("test mode moved without write");
  property p_ends; transmit_pending[0] == 1'b0 && transmit_pending[31] == 1'b0; endproperty
  a_ends: assert property (p_ends) else $error("receive-only box pending");
  property p_pend;
    (transmit_pending & ~$past(transmit_pending)) != 32'h0 |-> $past(avs_write && !avs_waitrequest);
  endproperty
  a_pend: assert property (p_pend) else $error("pending set without write");
  property p_cancel;
    (transmit_cancel & ~$past(transmit_cancel) & ~$past(transmit_pending)) == 32'h0;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel set on idle box");
  property p_done;
    (tx_complete & transmit_pending) != 32'h0 |=> (transmit_pending & $past(tx_complete)) == 32'h0;
  endproperty
  a_done: assert property (p_done) else $error("pending kept after completion");
  property p_passive;
    $rose(error_passive) |-> $past((avs_write && !avs_waitrequest) || tx_error || rx_error);
  endproperty
  a_passive: assert property (p_passive) else $error("passive without cause");
endmodule // can_regs_asserts

// ---- dv/can_node.sv ----
// Model of the far CAN side that raises completion and reception events.
`timescale 1ns/1ps
module can_node (
  input  wire logic        mclk,
  output logic      [31:0] tx_complete,
  output logic      [31:0] tx_aborted,
  output logic      [31:0] rx_data_frame,
  output logic      [31:0] rx_remote_frame,
  output logic             rx_store,
  output logic      [4:0]  rx_mailbox,
  output logic      [10:0] rx_identifier,
  output logic             tx_error,
  output logic             tx_success,
  output logic             rx_error,
  output logic             rx_success,
  output logic             frame_start,
  output logic             frame_end
);
  // Idle mailbox and identifier values flip so a stale identifier is never mistaken for a live one.
  task automatic clr();
    {tx_complete, tx_aborted, rx_data_frame, rx_remote_frame} <= 128'h0;
    {rx_store, tx_error, tx_success, rx_error, rx_success, frame_start, frame_end} <= 7'h00;
    rx_mailbox <= ~rx_mailbox;
    rx_identifier <= ~rx_identifier;
  endtask
  initial begin
    rx_mailbox = 5'h00;
    rx_identifier = 11'h000;
    clr();
  end
  task automatic ev(input int k, input logic [31:0] m, input logic [10:0] id);
    @(posedge mclk);
    case (k)
      0: tx_complete <= m;
      1: tx_aborted <= m;
      2: rx_data_frame <= m;
      3: rx_remote_frame <= m;
      4: {frame_end, frame_start} <= m[1:0];
      5: {rx_success, tx_success, rx_error, tx_error} <= m[3:0];
      default: begin
        rx_store <= 1'b1;
        rx_mailbox <= m[4:0];
        rx_identifier <= id;
      end
    endcase
    @(posedge mclk);
    clr();
  endtask
endmodule // can_node

// ---- dv/tb_top.sv ----
// Self-checking bench for the register block.
`timescale 1ns/1ps
module tb_top;
  import can_pkg::*;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [31:0] tx_complete, tx_aborted, rx_data_frame, rx_remote_frame;
  logic        rx_store, tx_error, tx_success, rx_error, rx_success;
  logic        frame_start, frame_end, id_compare_match;
  logic [4:0]  rx_mailbox;
  logic [10:0] rx_identifier;
  logic [31:0] transmit_pending, transmit_cancel, acceptance_mask_on;
  logic        error_passive, test_mode, mailbox_request, timer_request;
  logic [15:0] q;
  int          err_count = 0, checks_done = 0, cyc = 0, n;
  can_regs #(.MAILBOXES(32)) DUT (.*);
  can_node node (.*);
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  // ==========================================================================
  // Bus and compare helpers
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
    checks_done++;
    if (v !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, 4'h3);
    chk($sformatf("reg_%h", a), e, q);
  endtask
  task automatic bit_chk(input string s, input logic e, input logic v);
    chk(s, {15'h0000, e}, {15'h0000, v});
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_counters();
    wr(ERROR_COUNTERS, 16'h5500);
    rc(ERROR_COUNTERS, 16'h0000);
    wr(MASTER_CONTROL, 16'hc000);
    bit_chk("test_mode", 1'b1, test_mode);
    wr(ERROR_COUNTERS, 16'hff00);
    rc(ERROR_COUNTERS, 16'hffff);
    node.ev(5, 32'h0000_0003, 11'h000);
    rc(ERROR_COUNTERS, 16'hffff);
    bit_chk("passive", 1'b1, error_passive);
    wr(ERROR_COUNTERS, 16'h0000);
    node.ev(5, 32'h0000_0001, 11'h000);
    rc(ERROR_COUNTERS, 16'h0800);
    node.ev(5, 32'h0000_0004, 11'h000);
    rc(ERROR_COUNTERS, 16'h0700);
    node.ev(5, 32'h0000_0002, 11'h000);
    rc(ERROR_COUNTERS, 16'h0701);
    wr(MASTER_CONTROL, 16'h2000);
    bit_chk("passive", 1'b0, error_passive);
    wr(MASTER_CONTROL, 16'he000);
    bit_chk("passive", 1'b1, error_passive);
    wr(MASTER_CONTROL, 16'h0000);
    $display("counters done");
  endtask
  task automatic t_mailbox_sets();
    rc(MAILBOX_IRQ_MASK, 16'hffff);
    wr(TRANSMIT_PENDING, 16'hffff);
    wr(TRANSMIT_PENDING + 8'h01, 16'hffff);
    rc(TRANSMIT_PENDING, 16'hfffe);
    rc(TRANSMIT_PENDING + 8'h01, 16'h7fff);
    wr(TRANSMIT_CANCEL, 16'h0007);
    rc(TRANSMIT_CANCEL, 16'h0006);
    node.ev(0, 32'h0000_0002, 11'h000);
    node.ev(1, 32'h0000_0004, 11'h000);
    rc(TRANSMIT_DONE, 16'h0002);
    rc(ABORT_DONE, 16'h0004);
    rc(TRANSMIT_PENDING, 16'hfff8);
    bit_chk("mbox_req", 1'b0, mailbox_request);
    wr(MAILBOX_IRQ_MASK, 16'hfffd);
    bit_chk("mbox_req", 1'b1, mailbox_request);
    wr(TRANSMIT_DONE, 16'h0002);
    rc(TRANSMIT_DONE, 16'h0000);
    repeat (2) node.ev(2, 32'h0001_0008, 11'h000);
    node.ev(3, 32'h0000_0010, 11'h000);
    rc(DATA_RECEIVED + 8'h01, 16'h0001);
    rc(REMOTE_RECEIVED, 16'h0010);
    rc(OVERWRITE_STATUS, 16'h0008);
    rc(OVERWRITE_STATUS + 8'h01, 16'h0001);
    $display("mailbox sets done");
  endtask
  task automatic t_timer();
    rc(SYNC_CAPTURE, 16'h0000);
    wr(TIMER_RELOAD_OFFSET, 16'h0100);
    wr(TIMER_COMPARE_ZERO, 16'h0105);
    wr(TIMER_COMPARE_ONE, 16'h0000);
    wr(INTERRUPT_MASK, 16'hbfff);
    wr(TIMER_CONTROL, 16'h8800);
    for (n = 0; n < 2000 && timer_request !== 1'b1; n++) @(posedge mclk);
    wr(TIMER_CONTROL, 16'h0000);
    bit_chk("tmr_req", 1'b1, timer_request);
    rc(INTERRUPT_FLAGS, 16'h4000);
    rc(TIMER_STATUS, 16'h0002);
    bus(1'b0, TIMER_COUNT, 16'h0000, 4'h3);
    bit_chk("count", 1'b1, q >= 16'h0100 && q <= 16'h0105);
    wr(INTERRUPT_FLAGS, 16'h4000);
    rc(TIMER_STATUS, 16'h0000);
    wr(TIMER_COUNT, 16'h1234);
    wr(TIMER_CONTROL, 16'h4000);
    node.ev(4, 32'h0000_0001, 11'h000);
    rc(SYNC_CAPTURE, 16'h1234);
    wr(TIMER_COUNT, 16'h4321);
    wr(TIMER_CONTROL, 16'h2000);
    node.ev(4, 32'h0000_0002, 11'h000);
    rc(SYNC_CAPTURE, 16'h1234);
    rc(TIMESTAMP_CAPTURE, 16'h4321);
    id_compare_match <= 1'b1;
    @(posedge mclk);
    id_compare_match <= 1'b0;
    rc(TIMER_COUNT, 16'h0100);
    $display("timer done");
  endtask
  task automatic t_store();
    for (int c = 0; c < 8; c++) begin
      wr(8'h48, 16'(c));
      bit_chk("mask_on", c inside {1, 2, 4, 5}, acceptance_mask_on[2]);
    end
    wr(8'h48, 16'h0001);
    node.ev(6, 32'h0000_0002, 11'h2ab);
    rc(8'h48, 16'h5561);
    bus(1'b1, 8'h48, 16'h0000, 4'h1);
    rc(8'h48, 16'h5561);
    wr(8'h49, 16'h1234);
    bus(1'b1, 8'h49, 16'h00ff, 4'h1);
    rc(8'h49, 16'h12ff);
    $display("mailbox store done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst, avs_read, avs_write, id_compare_match} = 4'h8;
    {avs_address, avs_writedata, avs_byteenable} = 44'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rc(INTERRUPT_MASK, 16'hffff);
    t_counters();
    t_mailbox_sets();
    t_timer();
    t_store();
    close_out();
  end
endmodule // tb_top
bind can_regs can_regs_asserts chk_i (.*);
